//--- dv/dhi_chk_sva.sv
`include "dhi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dhi_chk #(
  parameter int W = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [`DHI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire dhi_pkg::dhi_mode_e dpll_mode,
  input wire logic [W-1:0] loop_filter_word,
  input wire logic [W-1:0] tuning_word
);
  import dhi_pkg::*;
  // ********************
  // bus and tuning checks
  // ********************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);
  // both write halves taken at one edge
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready &&
    !s_axi_wready) else $error("write taken while response pending");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while data pending");
  a_rd_unmapped: assert property (s_rd_taken ##0 (s_axi_araddr > 8'h27)
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
  a_locked_word: assert property (!sys_rst && dpll_mode == DHI_LOCKED
    |=> tuning_word == $past(loop_filter_word)) else $error("locked word");
endmodule // dhi_chk
bind dhi_top dhi_chk #(.W(W)) i_chk (
  .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .dpll_mode,
  .loop_filter_word, .tuning_word
);
`default_nettype wire

//--- dv/dhi_host_mdl.sv
`include "dhi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module dhi_host_mdl (
  input wire logic [`DHI_NUM_GPIO-1:0] gpio_out,
  input wire logic [`DHI_NUM_GPIO-1:0] gpio_oe_n,
  output logic [`DHI_NUM_GPIO-1:0] pin
);
  // host side pins carry pull-ups: a released pin reads high
  assign pin = gpio_oe_n | gpio_out;
endmodule // dhi_host_mdl
`default_nettype wire

//--- dv/tb.sv
`include "dhi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dhi_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, ref_valid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, loop_filter_word = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  dhi_mode_e dpll_mode = DHI_FREE_RUN;
  logic [`DHI_NUM_SRC-1:0] live = 14'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, gpio_out, gpio_oe_n, pin, resp;
  logic [31:0] s_axi_rdata, tuning_word, rdat;
  int fail_count = 0;
  int n_checks = 0;
  // clock
  always #5 clk_sys = ~clk_sys;
  // ********************
  // device and host
  // ********************
  dhi_top #(.W(32)) i_dut (
    .clk_sys, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .dpll_mode, .loop_filter_word, .ref_valid,
    .xo_signal_loss(live[0]), .reference_loss(live[1]),
    .apll_lock_loss(live[4:2]), .dpll_lock_loss(live[7:5]),
    .dpll_holdover(live[10:8]), .dpll_switchover(live[13:11]),
    .tuning_word, .gpio_out, .gpio_oe_n
  );
  dhi_host_mdl i_host (.gpio_out, .gpio_oe_n, .pin);
  // ********************
  // bus tasks
  // ********************
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
    s_axi_bready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    n_checks++;
    if (s !== e)
    begin
      $display("unexpected %s: expected %h, seen %h", n, e, s);
      fail_count++;
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk($sformatf("reg %h", a), e, rdat);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // lock with a steady filter word for six intervals of four cycles
  task automatic build(input logic [31:0] v);
    loop_filter_word <= v;
    ref_valid <= 1'b1;
    dpll_mode <= DHI_LOCKED;
    cyc(24);
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog against a hung handshake
  initial
  begin
    #300000;
    fail_count++;
    print_verdict();
  end
  // ********************
  // tests
  // ********************
  initial
  begin
    cyc(4);
    sys_rst <= 1'b0;
    cyc(1);
    rdc(`DHI_OFF_CTRL, 32'h0);
    rdc(`DHI_OFF_PERIOD, 32'h10);
    rdc(`DHI_OFF_MASK, 32'h3FFF);
    rdc(`DHI_OFF_STICKY, 32'h0);
    rd(8'h40);
    chk("rresp", 32'h2, 32'(resp));
    wr(8'h40, 32'h1);
    chk("bresp", 32'h2, 32'(resp));
    wr(`DHI_OFF_STICKY, 32'h1);
    chk("bresp ro", 32'h0, 32'(resp));
    // free run and holdover without history
    wr(`DHI_OFF_FREE_RUN, 32'h0ABC_0000);
    cyc(2);
    chk("tune free", 32'h0ABC_0000, tuning_word);
    dpll_mode <= DHI_HOLDOVER;
    cyc(3);
    chk("tune hold", 32'h0ABC_0000, tuning_word);
    // history over intervals of four cycles, then a late fault
    wr(`DHI_OFF_CTRL, 32'h1);
    wr(`DHI_OFF_PERIOD, 32'h2);
    build(32'h0000_1234);
    chk("tune lock", 32'h0000_1234, tuning_word);
    rdc(`DHI_OFF_HIST, 32'h3);
    loop_filter_word <= 32'h0000_5678;
    cyc(3);
    ref_valid <= 1'b0;
    dpll_mode <= DHI_HOLDOVER;
    cyc(3);
    chk("tune hold", 32'h0000_1234, tuning_word);
    rdc(`DHI_OFF_HIST, 32'h1);
    // brief relock and second holdover keep the history
    loop_filter_word <= 32'h0000_9999;
    ref_valid <= 1'b1;
    dpll_mode <= DHI_LOCKED;
    cyc(2);
    ref_valid <= 1'b0;
    dpll_mode <= DHI_HOLDOVER;
    cyc(3);
    chk("tune hold", 32'h0000_1234, tuning_word);
    wr(`DHI_OFF_CTRL, 32'h0);
    wr(`DHI_OFF_CTRL, 32'h1);
    cyc(2);
    chk("tune hold", 32'h0ABC_0000, tuning_word);
    rdc(`DHI_OFF_HIST, 32'h0);
    rdc(`DHI_OFF_TUNE, 32'h0ABC_0000);
    // reset in mid-run drops history
    build(32'h0000_1234);
    sys_rst <= 1'b1;
    cyc(2);
    sys_rst <= 1'b0;
    cyc(1);
    rdc(`DHI_OFF_HIST, 32'h0);
    // every source raises the interrupt on gpio0
    wr(`DHI_OFF_GPIO0, 32'hE);
    wr(`DHI_OFF_MASK, 32'h0);
    wr(`DHI_OFF_CTRL, 32'h6);
    for (int i = 0; i < `DHI_NUM_SRC; i++)
    begin
      live[i] <= 1'b1;
      cyc(1);
      live[i] <= 1'b0;
      cyc(5);
      chk("irq pin", 32'h1, 32'(pin[0]));
      rdc(`DHI_OFF_STICKY, 32'h1 << i);
      wr(`DHI_OFF_CTRL, 32'h16);
      rdc(`DHI_OFF_CTRL, 32'h6);
      cyc(3);
      chk("irq pin", 32'h0, 32'(pin[0]));
    end
    // masked flag is held but silent
    wr(`DHI_OFF_MASK, 32'h3FFE);
    live[1] <= 1'b1;
    cyc(6);
    chk("irq pin", 32'h0, 32'(pin[0]));
    rdc(`DHI_OFF_STICKY, 32'h2);
    // and-combine of two unmasked flags
    wr(`DHI_OFF_MASK, 32'h3FFC);
    wr(`DHI_OFF_CTRL, 32'hE);
    cyc(4);
    chk("irq pin", 32'h0, 32'(pin[0]));
    live[0] <= 1'b1;
    cyc(5);
    chk("irq pin", 32'h1, 32'(pin[0]));
    // falling edge polarity
    wr(`DHI_OFF_CTRL, 32'h12);
    cyc(4);
    chk("irq pin", 32'h0, 32'(pin[0]));
    live[0] <= 1'b0;
    cyc(5);
    chk("irq pin", 32'h1, 32'(pin[0]));
    rdc(`DHI_OFF_STICKY, 32'h1);
    // interrupt logic disabled
    wr(`DHI_OFF_CTRL, 32'h10);
    live[0] <= 1'b1;
    cyc(2);
    live[0] <= 1'b0;
    cyc(5);
    chk("irq pin", 32'h0, 32'(pin[0]));
    rdc(`DHI_OFF_STICKY, 32'h0);
    // gpio1 shows inverted xo loss, push-pull then open drain
    wr(`DHI_OFF_GPIO1, 32'h20);
    cyc(3);
    chk("gpio1", 32'h1, 32'(pin[1]));
    live[0] <= 1'b1;
    cyc(3);
    chk("gpio1", 32'h0, 32'(pin[1]));
    wr(`DHI_OFF_GPIO1, 32'h60);
    live[0] <= 1'b0;
    cyc(3);
    chk("gpio1 oe_n", 32'h1, 32'(gpio_oe_n[1]));
    chk("gpio1 out", 32'h0, 32'(gpio_out[1]));
    live[0] <= 1'b1;
    cyc(3);
    chk("gpio1 oe_n", 32'h0, 32'(gpio_oe_n[1]));
    chk("gpio1", 32'h0, 32'(pin[1]));
    print_verdict();
  end
endmodule // tb
`default_nettype wire

//--- src/dhi_defs.svh
`ifndef DHI_DEFS_SVH
`define DHI_DEFS_SVH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define DHI_ADDR_W 8
`define DHI_OFF_CTRL 8'h00
`define DHI_OFF_PERIOD 8'h04
`define DHI_OFF_FREE_RUN 8'h08
`define DHI_OFF_MASK 8'h0C
`define DHI_OFF_STICKY 8'h10
`define DHI_OFF_LIVE 8'h14
`define DHI_OFF_GPIO0 8'h18
`define DHI_OFF_GPIO1 8'h1C
`define DHI_OFF_TUNE 8'h20
`define DHI_OFF_HIST 8'h24

// ***************************************************************
// field positions
// ***************************************************************
`define DHI_CTRL_HIST_EN 0
`define DHI_CTRL_IRQ_EN 1
`define DHI_CTRL_IRQ_POL 2
`define DHI_CTRL_AND_SEL 3
`define DHI_CTRL_CLR 4
`define DHI_GPIO_POL 5
`define DHI_GPIO_OD 6
`define DHI_SRC_XO 0
`define DHI_SRC_REF 1
`define DHI_SRC_APLL 2
`define DHI_SRC_DLOCK 5
`define DHI_SRC_HOLD 8
`define DHI_SRC_SWITCH 11

// ***************************************************************
// sizes and reset values
// ***************************************************************
`define DHI_NUM_SRC 14
`define DHI_NUM_PLL 3
`define DHI_NUM_GPIO 2
`define DHI_SEL_IRQ 5'h0E
`define DHI_RST_CTRL 4'h0
`define DHI_RST_PERIOD 5'h10
`define DHI_RST_FREE_RUN 32'h0000_0000
`define DHI_RST_MASK 14'h3FFF
`define DHI_RST_GPIO 7'h00

`endif

//--- src/dhi_history.sv
`timescale 1ns/1ps
`default_nettype none
module dhi_history #(
  parameter int W = 32,
  parameter int PW = 5
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire dhi_pkg::dhi_mode_e mode,
  input wire logic [W-1:0] lf_word,
  input wire logic ref_valid,
  input wire logic hist_en,
  input wire logic [PW-1:0] period,
  input wire logic [W-1:0] free_run,
  output logic [W-1:0] tune_word,
  output logic hist_vld,
  output logic newest_vld
);
  import dhi_pkg::*;
  localparam int ACC = W + 32;

  typedef struct packed {
    dhi_hist_st_e st;
    logic [ACC-1:0] acc;
    logic [31:0] cnt;
    logic [W-1:0] newest;
    logic [W-1:0] hist;
    logic hist_vld;
    logic newest_vld;
    logic en_d;
    logic [W-1:0] word;
  } dhi_hist_s;

  dhi_hist_s r, n;
  logic active;
  logic [ACC-1:0] sum;
  logic [31:0] lim;

  // ***************************************************************
  // accumulation and tuning word selection
  // ***************************************************************
  always_comb
  begin
    n = r;
    active = hist_en && (mode == DHI_LOCKED) && ref_valid;
    sum = r.acc + ACC'(lf_word);
    lim = (32'h1 << period) - 32'h1;
    n.en_d = hist_en;
    case (r.st)
      DHI_H_IDLE:
      begin
        n.acc = '0;
        n.cnt = '0;
        if (active)
          n.st = DHI_H_FIRST;
      end
      DHI_H_FIRST, DHI_H_RUN:
      begin
        if (!active)
        begin
          // partial interval is thrown away, stored history kept
          n.st = DHI_H_IDLE;
          n.acc = '0;
          n.cnt = '0;
          if (!ref_valid)
            n.newest_vld = 1'b0;
        end
        else if (r.cnt == lim)
        begin
          n.acc = '0;
          n.cnt = '0;
          n.st = DHI_H_RUN;
          if (r.st == DHI_H_RUN)
          begin
            // store only on a complete interval
            n.newest = W'(sum >> period);
            n.newest_vld = 1'b1;
            if (r.newest_vld)
            begin
              n.hist = r.newest;
              n.hist_vld = 1'b1;
            end
          end
        end
        else
        begin
          n.acc = sum;
          n.cnt = r.cnt + 32'h1;
        end
      end
      default:
        n.st = DHI_H_IDLE;
    endcase
    // enable toggled off discards everything
    if (r.en_d && !hist_en)
    begin
      n.st = DHI_H_IDLE;
      n.hist_vld = 1'b0;
      n.newest_vld = 1'b0;
      n.hist = '0;
      n.newest = '0;
    end
    case (mode)
      DHI_LOCKED: n.word = lf_word;
      DHI_HOLDOVER: n.word = r.hist_vld ? r.hist : free_run;
      default: n.word = free_run;
    endcase
  end

  // ***************************************************************
  // state register, history cleared on reset
  // ***************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  assign tune_word = r.word;
  assign hist_vld = r.hist_vld;
  assign newest_vld = r.newest_vld;
endmodule // dhi_history
`default_nettype wire

//--- src/dhi_pkg.sv
package dhi_pkg;

  // dpll operating mode as reported by the loop
  typedef enum logic [1:0] {
    DHI_LOCKED = 2'b00,
    DHI_HOLDOVER = 2'b01,
    DHI_FREE_RUN = 2'b10
  } dhi_mode_e;

  // history monitor states
  typedef enum logic [1:0] {
    DHI_H_IDLE = 2'b00,
    DHI_H_FIRST = 2'b01,
    DHI_H_RUN = 2'b10
  } dhi_hist_st_e;

  // axi response codes
  typedef enum logic [1:0] {
    DHI_RESP_OKAY = 2'b00,
    DHI_RESP_SLVERR = 2'b10
  } dhi_resp_e;

endpackage

//--- src/dhi_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module dhi_sticky #(
  parameter int N = 14
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [N-1:0] live,
  input wire logic pol,
  input wire logic en,
  input wire logic and_sel,
  input wire logic [N-1:0] mask,
  input wire logic clr,
  output logic [N-1:0] flags,
  output logic irq
);
  typedef struct packed {
    logic [N-1:0] prev;
    logic [N-1:0] flags;
    logic irq;
  } dhi_stk_s;

  dhi_stk_s r, n;
  logic [N-1:0] set;

  // ***************************************************************
  // edge capture, sticky hold and combine
  // ***************************************************************
  always_comb
  begin
    n = r;
    n.prev = live;
    set = pol ? (live & ~r.prev) : (~live & r.prev);
    if (!en)
      set = '0;
    // a new edge beats a clear in the same cycle
    n.flags = (r.flags & ~{N{clr}}) | set;
    if (!en || (&mask))
      n.irq = 1'b0;
    else if (and_sel)
      n.irq = &(r.flags | mask);
    else
      n.irq = |(r.flags & ~mask);
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= n;
  end

  assign flags = r.flags;
  assign irq = r.irq;
endmodule // dhi_sticky
`default_nettype wire

//--- src/dhi_top.sv
`include "dhi_defs.svh"
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - tuning word from filter, history or free-run
// - average filter output over programmable interval
// - keep the average before the newest when reference fails
// - reference failure drops partial and newest average
// - reset clears all history
// - first interval after lock is not stored
// - history survives switchover and holdover exit
// - enable one-zero-one clears history
// - no history means holdover uses free-run word
// - gpio selects status, driver type, polarity
// - any gpio carries interrupt; enable gates it
// - sources: xo, reference, lock, holdover, switchover
// - polarity picks rising or falling edge
// - each flag has its own mask
// - unmasked flags combined by and or or
// - clear field is write one, self clearing
// - lock-loss status for every apll and dpll
module dhi_top #(
  parameter int W = 32
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`DHI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`DHI_ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  input wire dhi_pkg::dhi_mode_e dpll_mode,
  input wire logic [W-1:0] loop_filter_word,
  input wire logic ref_valid,
  input wire logic xo_signal_loss,
  input wire logic reference_loss,
  input wire logic [`DHI_NUM_PLL-1:0] apll_lock_loss,
  input wire logic [`DHI_NUM_PLL-1:0] dpll_lock_loss,
  input wire logic [`DHI_NUM_PLL-1:0] dpll_holdover,
  input wire logic [`DHI_NUM_PLL-1:0] dpll_switchover,
  output logic [W-1:0] tuning_word,
  output logic [`DHI_NUM_GPIO-1:0] gpio_out,
  output logic [`DHI_NUM_GPIO-1:0] gpio_oe_n
);
  import dhi_pkg::*;
  localparam int NS = `DHI_NUM_SRC;

  // ***************************************************************
  // register map, byte offsets
  // ***************************************************************
  // 00 control: history enable, irq enable, rising polarity,
  //    and-combine select, clear (write one, reads as zero)
  // 04 averaging period: one interval is two to this power cycles
  // 08 free-run tuning word, used in free run and in holdover without history
  // 0c flag mask, one bit per source, a set bit silences it
  // 10 sticky flags and 14 live status, both read only
  // 18 and 1c pin setup: source select, invert, open drain
  // 20 selected tuning word and 24 history state, read only
  // any other offset answers with a slave error
  // sources: 0 xo, 1 reference, 4:2 apll lock loss,
  //    7:5 dpll lock loss, 10:8 holdover, 13:11 switchover

  // whole register state of the block in one struct
  typedef struct packed {
    logic aw_got;
    logic [`DHI_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] ctrl;
    logic [4:0] period;
    logic [W-1:0] free_run;
    logic [NS-1:0] mask;
    logic [`DHI_NUM_GPIO-1:0][6:0] gpio_cfg;
    logic clr;
    logic [`DHI_NUM_GPIO-1:0] gpio_o;
    logic [`DHI_NUM_GPIO-1:0] gpio_oen;
  } dhi_top_s;

  dhi_top_s r, n;
  // results of the submodules and decode scratch
  logic [NS-1:0] live;
  logic [NS-1:0] flags;
  logic irq;
  logic [W-1:0] tune;
  logic hist_vld;
  logic newest_vld;
  logic [32:0] rd;
  logic [`DHI_ADDR_W-1:0] wa;
  logic drv;

  // ***************************************************************
  // helper functions
  // ***************************************************************

  // byte-lane merge of a write into a register word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[8*i +: 8] = nw[8*i +: 8];
    return res;
  endfunction

  // word-aligned form of a bus address
  function automatic logic [`DHI_ADDR_W-1:0] align(
    input logic [`DHI_ADDR_W-1:0] a);
    return {a[`DHI_ADDR_W-1:2], 2'b00};
  endfunction

  // level of the status or interrupt chosen for one pin
  function automatic logic src_level(input logic [4:0] sel,
                                     input logic [NS-1:0] stat,
                                     input logic intr);
    logic lvl;
    lvl = 1'b0; // unused selections read low
    if (sel == `DHI_SEL_IRQ)
      lvl = intr;
    else if (sel < 5'(NS))
      lvl = stat[sel[3:0]];
    return lvl;
  endfunction

  // ***************************************************************
  // live status vector
  // ***************************************************************

  // lock loss of each pll, loss and mode events
  // order fixes the bit of each source in the flag registers
  assign live = {dpll_switchover, dpll_holdover, dpll_lock_loss,
                 apll_lock_loss, reference_loss, xo_signal_loss};

  // ***************************************************************
  // tuning word history
  // ***************************************************************
  // averaging runs in the submodule, period from the register
  dhi_history #(
    .W(W),
    .PW(5)
  ) u_hist (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .mode(dpll_mode),
    .lf_word(loop_filter_word),
    .ref_valid(ref_valid),
    .hist_en(r.ctrl[`DHI_CTRL_HIST_EN]),
    .period(r.period),
    .free_run(r.free_run),
    .tune_word(tune),
    .hist_vld(hist_vld),
    .newest_vld(newest_vld)
  );

  // ***************************************************************
  // sticky flags and interrupt
  // ***************************************************************
  // one flag per source, edge caught in the submodule
  dhi_sticky #(
    .N(NS)
  ) u_sticky (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .live(live),
    .pol(r.ctrl[`DHI_CTRL_IRQ_POL]),
    .en(r.ctrl[`DHI_CTRL_IRQ_EN]),
    .and_sel(r.ctrl[`DHI_CTRL_AND_SEL]),
    .mask(r.mask),
    .clr(r.clr),
    .flags(flags),
    .irq(irq)
  );

  // ***************************************************************
  // register read decode
  // ***************************************************************

  // slave error flag in bit 32, data below it
  // low address bits are dropped: each register is one word
  always_comb
  begin
    rd = {1'b0, 32'h0000_0000};
    case (align(s_axi_araddr))
      `DHI_OFF_CTRL: rd[3:0] = r.ctrl; // clear field reads zero
      `DHI_OFF_PERIOD: rd[4:0] = r.period;
      `DHI_OFF_FREE_RUN: rd[W-1:0] = r.free_run;
      `DHI_OFF_MASK: rd[NS-1:0] = r.mask;
      `DHI_OFF_STICKY: rd[NS-1:0] = flags;
      `DHI_OFF_LIVE: rd[NS-1:0] = live;
      `DHI_OFF_GPIO0: rd[6:0] = r.gpio_cfg[0];
      `DHI_OFF_GPIO1: rd[6:0] = r.gpio_cfg[1];
      `DHI_OFF_TUNE: rd[W-1:0] = tune;
      `DHI_OFF_HIST: rd[1:0] = {newest_vld, hist_vld};
      default: rd[32] = 1'b1;
    endcase
  end

  // ***************************************************************
  // bus handshake, register writes and gpio routing
  // ***************************************************************
  // readies are combinational; each half waits while one is held
  // a pending response blocks new writes, pending data new reads
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;

  always_comb
  begin
    n = r;
    // clear request lasts one cycle only
    n.clr = 1'b0;
    wa = align(r.aw_addr);
    drv = 1'b0;
    // address and data are captured in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      n.aw_got = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      n.w_got = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    // response leaves once the master has taken it
    if (r.bvalid && s_axi_bready)
      n.bvalid = 1'b0;
    // write performed once both halves are held
    if (r.aw_got && r.w_got)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = DHI_RESP_OKAY;
      // merged words are cut to the stored width of each register
      case (wa)
        `DHI_OFF_CTRL:
        begin
          n.ctrl = 4'(merge(32'(r.ctrl), r.w_data, r.w_strb));
          // clear is a pulse and never stored
          n.clr = r.w_strb[0] && r.w_data[`DHI_CTRL_CLR];
        end
        `DHI_OFF_PERIOD:
          n.period = 5'(merge(32'(r.period), r.w_data, r.w_strb));
        `DHI_OFF_FREE_RUN:
          n.free_run = W'(merge(32'(r.free_run), r.w_data, r.w_strb));
        `DHI_OFF_MASK:
          n.mask = NS'(merge(32'(r.mask), r.w_data, r.w_strb));
        `DHI_OFF_GPIO0:
          n.gpio_cfg[0] = 7'(merge(32'(r.gpio_cfg[0]), r.w_data,
                                   r.w_strb));
        `DHI_OFF_GPIO1:
          n.gpio_cfg[1] = 7'(merge(32'(r.gpio_cfg[1]), r.w_data,
                                   r.w_strb));
        `DHI_OFF_STICKY, `DHI_OFF_LIVE, `DHI_OFF_TUNE, `DHI_OFF_HIST:
          n.bresp = DHI_RESP_OKAY; // read-only, write ignored
        default:
          n.bresp = DHI_RESP_SLVERR;
      endcase
    end
    // read answer captured at the address handshake
    // data are frozen then, so a slow master sees a stable word
    if (r.rvalid && s_axi_rready)
      n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd[31:0];
      n.rresp = rd[32] ? DHI_RESP_SLVERR : DHI_RESP_OKAY;
    end
    // status or interrupt per pin, then polarity and driver type
    // the pin follows its source one cycle later, so a short
    // status pulse still reaches the pin
    for (int g = 0; g < `DHI_NUM_GPIO; g++)
    begin
      drv = src_level(r.gpio_cfg[g][4:0], live, irq);
      drv = drv ^ r.gpio_cfg[g][`DHI_GPIO_POL];
      // open drain only pulls low; a high level is left to the pull-up
      if (r.gpio_cfg[g][`DHI_GPIO_OD])
      begin
        n.gpio_o[g] = 1'b0;
        n.gpio_oen[g] = drv;
      end
      else
      begin
        n.gpio_o[g] = drv;
        n.gpio_oen[g] = 1'b0;
      end
    end
  end

  // ***************************************************************
  // state register
  // ***************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      // everything to zero, then the reset value of each register from the defines
      r <= '0;
      r.ctrl <= `DHI_RST_CTRL;
      r.period <= `DHI_RST_PERIOD;
      r.free_run <= W'(`DHI_RST_FREE_RUN);
      r.mask <= `DHI_RST_MASK;
      r.gpio_cfg <= {`DHI_NUM_GPIO{`DHI_RST_GPIO}};
    end
    else
      r <= n;
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // bus answers and pin levels straight from flip-flops
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign tuning_word = tune;
  assign gpio_out = r.gpio_o;
  assign gpio_oe_n = r.gpio_oen;
endmodule // dhi_top
`default_nettype wire
